// [dcdt_pkg.sv]
// Purpose: constants for the dual channel down timer
// Assumes: 32-bit register words at full byte addresses
// Notes:   mode codes follow the control field encoding
`default_nettype none
package dcdt_pkg;
	// channel count and widths
	localparam int DCDT_NCH = 2;
	localparam int DCDT_CNT_W = 24;
	localparam int DCDT_PRE_W = 8;
	// register byte addresses
	localparam logic [31:0] DCDT_CTRL_ADDR [DCDT_NCH] = '{32'hFFF81000, 32'hFFF81004};
	localparam logic [31:0] DCDT_INIT_ADDR [DCDT_NCH] = '{32'hFFF81008, 32'hFFF8100C};
	localparam logic [31:0] DCDT_CUR_ADDR  [DCDT_NCH] = '{32'hFFF81010, 32'hFFF81014};
	localparam logic [31:0] DCDT_STAT_ADDR = 32'hFFF81018;
	// control field positions
	localparam int DCDT_HOLD_BIT = 31;
	localparam int DCDT_RUN_BIT = 30;
	localparam int DCDT_IRQ_BIT = 29;
	localparam int DCDT_MODE_HI = 28;
	localparam int DCDT_MODE_LO = 27;
	localparam int DCDT_CLR_BIT = 26;
	localparam int DCDT_ACT_BIT = 25;
	localparam int DCDT_PRE_HI = 7;
	// reset values and unit step constants
	localparam logic [DCDT_PRE_W-1:0] DCDT_PRE_RST = 8'h05;
	localparam logic [DCDT_CNT_W-1:0] DCDT_CNT_RST = 24'h000000;
	localparam logic [DCDT_PRE_W-1:0] DCDT_PRE_ZERO = 8'h00;
	localparam logic [DCDT_PRE_W-1:0] DCDT_PRE_ONE = 8'h01;
	localparam logic [DCDT_CNT_W-1:0] DCDT_CNT_ONE = 24'h000001;
	localparam logic [31:0] DCDT_WORD_ZERO = 32'h00000000;
	// operating modes
	typedef enum logic [1:0] {
		DCDT_ONE_SHOT = 2'h0,
		DCDT_PERIODIC = 2'h1,
		DCDT_TOGGLE   = 2'h2,
		DCDT_RSVD     = 2'h3
	} dcdt_mode_t;
endpackage
`default_nettype wire

// [dcdt_timer.sv]
// Purpose: two channel prescaled 24-bit down timer behind an apb slave
// Assumes: all inputs synchronous to mclk; source clocks slower than mclk/2
// Notes:   channel source clocks are sampled and counted on rising edges
`timescale 1ns/10ps
`default_nettype none
module dcdt_timer
(
	// clock, reset, enable
	input  wire logic                          mclk,
	input  wire logic                          rst_b,
	input  wire logic                          ce,
	// apb slave
	input  wire logic                          psel,
	input  wire logic                          penable,
	input  wire logic                          pwrite,
	input  wire logic [31:0]                   paddr,
	input  wire logic [31:0]                   pwdata,
	output var  logic [31:0]                   prdata,
	output var  logic                          pready,
	output var  logic                          pslverr,
	// channel sources and debug
	input  wire logic [dcdt_pkg::DCDT_NCH-1:0] channel_source_clock,
	input  wire logic                          debug_acknowledge_in,
	// channel outputs
	output var  logic [dcdt_pkg::DCDT_NCH-1:0] timer_irq,
	output var  logic [dcdt_pkg::DCDT_NCH-1:0] toggle_out
);
	import dcdt_pkg::*;

	// true when the address names a given register
	function automatic logic addr_hit(input logic [31:0] a, input logic [31:0] r);
		addr_hit = (a == r);
	endfunction

	// apb phase strobes
	logic                  wr_acc;            // write access phase
	logic                  rd_setup;          // read setup phase
	logic                  mapped;            // address decodes
	logic                  stat_wr;           // status write
	logic [31:0]           prdata_q;          // registered read data
	logic [31:0]           rd_word;           // read mux result

	// per channel control and state
	logic                  hold_ovr_q [DCDT_NCH];
	logic                  run_q      [DCDT_NCH];
	logic                  irq_q      [DCDT_NCH];
	dcdt_mode_t            mode_q     [DCDT_NCH];
	logic [DCDT_PRE_W-1:0] prescale_q [DCDT_NCH];
	logic [DCDT_CNT_W-1:0] init_q     [DCDT_NCH];
	logic [DCDT_CNT_W-1:0] cnt_q      [DCDT_NCH];
	logic [DCDT_PRE_W-1:0] pre_q      [DCDT_NCH];
	logic                  src_prev_q [DCDT_NCH];
	logic                  flag_q     [DCDT_NCH];
	logic                  tog_q      [DCDT_NCH];
	// per channel events
	logic                  ctrl_wr    [DCDT_NCH];
	logic                  init_wr    [DCDT_NCH];
	logic                  clr_wr     [DCDT_NCH];
	logic                  held       [DCDT_NCH];
	logic                  step       [DCDT_NCH];
	logic                  pre_wrap   [DCDT_NCH];
	logic                  zero_ev    [DCDT_NCH];

	// write strobes carry ce so a frozen block ignores the bus
	assign wr_acc = psel & penable & pwrite & ce;
	assign rd_setup = psel & ~penable & ~pwrite & ce;
	assign stat_wr = wr_acc & addr_hit(paddr, DCDT_STAT_ADDR);

	// zero wait state slave, error on unmapped access
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~mapped;
	assign prdata = prdata_q;

	// address decode and read mux
	always_comb
	begin
		mapped = addr_hit(paddr, DCDT_STAT_ADDR);
		rd_word = DCDT_WORD_ZERO;
		if (addr_hit(paddr, DCDT_STAT_ADDR))
		begin
			for (int k = 0; k < DCDT_NCH; k++)
				rd_word[k] = flag_q[k];
		end
		for (int k = 0; k < DCDT_NCH; k++)
		begin
			if (addr_hit(paddr, DCDT_CTRL_ADDR[k]))
			begin
				mapped = 1'b1;
				rd_word[DCDT_HOLD_BIT] = hold_ovr_q[k];
				rd_word[DCDT_RUN_BIT] = run_q[k];
				rd_word[DCDT_IRQ_BIT] = irq_q[k];
				rd_word[DCDT_MODE_HI:DCDT_MODE_LO] = mode_q[k];
				rd_word[DCDT_ACT_BIT] = run_q[k];
				rd_word[DCDT_PRE_HI:0] = prescale_q[k];
			end
			if (addr_hit(paddr, DCDT_INIT_ADDR[k]))
			begin
				mapped = 1'b1;
				rd_word[DCDT_CNT_W-1:0] = init_q[k];
			end
			if (addr_hit(paddr, DCDT_CUR_ADDR[k]))
			begin
				mapped = 1'b1;
				rd_word[DCDT_CNT_W-1:0] = cnt_q[k];
			end
		end
	end

	// read data captured in setup so it is stable in access
	always_ff @(posedge mclk)
	begin
		if (!rst_b)
			prdata_q <= DCDT_WORD_ZERO;
		else if (rd_setup)
			prdata_q <= rd_word;
	end

	for (genvar i = 0; i < DCDT_NCH; i++)
	begin : g_ch
		// register write strobes
		assign ctrl_wr[i] = wr_acc & addr_hit(paddr, DCDT_CTRL_ADDR[i]);
		assign init_wr[i] = wr_acc & addr_hit(paddr, DCDT_INIT_ADDR[i]);
		assign clr_wr[i] = ctrl_wr[i] & pwdata[DCDT_CLR_BIT];
		assign held[i] = ~hold_ovr_q[i] & debug_acknowledge_in;
		assign step[i] = ce & run_q[i] & ~held[i]
			& channel_source_clock[i] & ~src_prev_q[i];
		assign pre_wrap[i] = (pre_q[i] == prescale_q[i]);
		// count of one or zero wraps at once
		assign zero_ev[i] = step[i] & pre_wrap[i] & (cnt_q[i] <= DCDT_CNT_ONE);
		assign timer_irq[i] = flag_q[i];
		assign toggle_out[i] = tog_q[i];

		// source edge detector history
		always_ff @(posedge mclk)
		begin
			if (!rst_b)
				src_prev_q[i] <= 1'b0;
			else if (ce)
				src_prev_q[i] <= channel_source_clock[i];
		end

		// control fields
		always_ff @(posedge mclk)
		begin
			if (!rst_b)
			begin
				hold_ovr_q[i] <= 1'b0;
				run_q[i] <= 1'b0;
				irq_q[i] <= 1'b0;
				mode_q[i] <= DCDT_ONE_SHOT;
				prescale_q[i] <= DCDT_PRE_RST;
			end
			else if (ctrl_wr[i])
			begin
				hold_ovr_q[i] <= pwdata[DCDT_HOLD_BIT];
				run_q[i] <= pwdata[DCDT_RUN_BIT] & ~pwdata[DCDT_CLR_BIT];
				irq_q[i] <= pwdata[DCDT_IRQ_BIT];
				mode_q[i] <= dcdt_mode_t'(pwdata[DCDT_MODE_HI:DCDT_MODE_LO]);
				prescale_q[i] <= pwdata[DCDT_PRE_HI:0];
			end
			else if (zero_ev[i] && mode_q[i] == DCDT_ONE_SHOT)
				run_q[i] <= 1'b0;
		end

		// initial count register
		always_ff @(posedge mclk)
		begin
			if (!rst_b)
				init_q[i] <= DCDT_CNT_RST;
			else if (init_wr[i])
				init_q[i] <= pwdata[DCDT_CNT_W-1:0];
		end

		// prescaler and down counter
		always_ff @(posedge mclk)
		begin
			if (!rst_b)
			begin
				cnt_q[i] <= DCDT_CNT_RST;
				pre_q[i] <= DCDT_PRE_ZERO;
			end
			else if (clr_wr[i])
			begin
				cnt_q[i] <= DCDT_CNT_RST;
				pre_q[i] <= DCDT_PRE_ZERO;
			end
			else if (init_wr[i])
			begin
				cnt_q[i] <= pwdata[DCDT_CNT_W-1:0];
				pre_q[i] <= DCDT_PRE_ZERO;
			end
			else if (step[i])
			begin
				if (!pre_wrap[i])
					pre_q[i] <= pre_q[i] + DCDT_PRE_ONE;
				else
				begin
					pre_q[i] <= DCDT_PRE_ZERO;
					if (zero_ev[i])
						cnt_q[i] <= init_q[i];
					else
						cnt_q[i] <= cnt_q[i] - DCDT_CNT_ONE;
				end
			end
		end

		// zero reached flag; a new event beats the clear
		always_ff @(posedge mclk)
		begin
			if (!rst_b)
				flag_q[i] <= 1'b0;
			else if (zero_ev[i] && irq_q[i])
				flag_q[i] <= 1'b1;
			else if (stat_wr && pwdata[i])
				flag_q[i] <= 1'b0;
		end

		// square wave; periodic in every other respect
		always_ff @(posedge mclk)
		begin
			if (!rst_b)
				tog_q[i] <= 1'b0;
			else if (zero_ev[i] && mode_q[i] == DCDT_TOGGLE)
				tog_q[i] <= ~tog_q[i];
		end

		// checks on this channel
		chk_clear_zeroes: assert property (@(posedge mclk) disable iff (!rst_b)
			clr_wr[i] |=> (cnt_q[i] == DCDT_CNT_RST) && (pre_q[i] == DCDT_PRE_ZERO) && !run_q[i])
			else $error("count clear did not clear channel");
		chk_init_restart: assert property (@(posedge mclk) disable iff (!rst_b)
			init_wr[i] |=> (cnt_q[i] == $past(pwdata[DCDT_CNT_W-1:0])) && (init_q[i] == cnt_q[i]))
			else $error("initial count write did not restart");
		chk_reload_value: assert property (@(posedge mclk) disable iff (!rst_b)
			zero_ev[i] && !init_wr[i] && !clr_wr[i] |=> cnt_q[i] == init_q[i])
			else $error("counter did not reload at zero");
		chk_flag_sets: assert property (@(posedge mclk) disable iff (!rst_b)
			zero_ev[i] && irq_q[i] |=> flag_q[i] && timer_irq[i])
			else $error("zero flag not set");
		chk_irq_masked: assert property (@(posedge mclk) disable iff (!rst_b)
			!irq_q[i] && !flag_q[i] && !ctrl_wr[i] |=> !timer_irq[i])
			else $error("interrupt raised while disabled");
		chk_oneshot_stop: assert property (@(posedge mclk) disable iff (!rst_b)
			zero_ev[i] && mode_q[i] == DCDT_ONE_SHOT && !ctrl_wr[i] |=> !run_q[i] ##1 !zero_ev[i])
			else $error("one shot kept running");
		chk_periodic_run: assert property (@(posedge mclk) disable iff (!rst_b)
			zero_ev[i] && mode_q[i] == DCDT_PERIODIC && !ctrl_wr[i] |=> run_q[i])
			else $error("periodic channel stopped");
		chk_toggle_flip: assert property (@(posedge mclk) disable iff (!rst_b)
			zero_ev[i] && mode_q[i] == DCDT_TOGGLE |=> toggle_out[i] != $past(toggle_out[i]))
			else $error("toggle output did not invert");
		chk_hold_freeze: assert property (@(posedge mclk) disable iff (!rst_b)
			(held[i] || !run_q[i]) && !init_wr[i] && !clr_wr[i] |=> $stable(cnt_q[i]) && $stable(pre_q[i]))
			else $error("counter moved while held or stopped");
		chk_prescale_step: assert property (@(posedge mclk) disable iff (!rst_b)
			step[i] && !pre_wrap[i] && !init_wr[i] && !clr_wr[i]
			|=> pre_q[i] == $past(pre_q[i]) + DCDT_PRE_ONE && $stable(cnt_q[i]))
			else $error("prescaler did not advance by one");

		// main scenarios
		cov_zero_irq: cover property (@(posedge mclk) disable iff (!rst_b)
			zero_ev[i] && irq_q[i]);
		cov_toggle: cover property (@(posedge mclk) disable iff (!rst_b)
			zero_ev[i] && mode_q[i] == DCDT_TOGGLE);
		cov_debug_hold: cover property (@(posedge mclk) disable iff (!rst_b)
			run_q[i] && held[i]);
	end
endmodule
`default_nettype wire

// [dcdt_apb_host.sv]
// Purpose: apb host model that drives the timer registers
// Assumes: the slave answers with pready in the access cycle
// Notes:   idle address and data lines show the inverse of the last value
`timescale 1ns/10ps
`default_nettype none
module dcdt_apb_host
(
	// clock
	input  wire logic        mclk,
	// apb master side
	output var  logic        psel,
	output var  logic        penable,
	output var  logic        pwrite,
	output var  logic [31:0] paddr,
	output var  logic [31:0] pwdata,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr
);
	// bus idle at time zero
	initial
	begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 32'h00000000;
		pwdata = 32'h00000000;
	end
	// one transfer: setup, access until pready, then release
	task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		int n;
		n = 0;
		@(posedge mclk);
		#1;
		psel = 1'b1;
		pwrite = w;
		paddr = a;
		pwdata = d;
		@(posedge mclk);
		#1;
		penable = 1'b1;
		@(posedge mclk);
		while (pready !== 1'b1 && n < 16)
		begin
			@(posedge mclk);
			n++;
		end
		// a slave that never answers ends the run as a failure
		if (n >= 16)
		begin
			tb_top.bad_count++;
			$display("MISMATCH pready exp 1 got 0");
			tb_top.stop_test();
		end
		q = prdata;
		e = pslverr;
		#1;
		psel = 1'b0;
		penable = 1'b0;
		// released lines must not keep the old value
		paddr = ~a;
		pwdata = ~d;
	endtask
endmodule
`default_nettype wire

// [tb_top.sv]
// Purpose: self-checking bench for the dual channel down timer
// Assumes: source clocks toggle every two mclk cycles
// Notes:   one source tick every four mclk cycles
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin bad_count++; \
	$display("MISMATCH %s exp %h got %h", n, e, s); end end
module tb_top;
	import dcdt_pkg::*;
	typedef struct packed {logic w; logic [31:0] a; logic [31:0] d; logic [31:0] x; logic er;} dcdt_row_t;
	logic        mclk, rst_b, ce, dbg, psel, penable, pwrite, pready, pslverr, e;
	logic [31:0] paddr, pwdata, prdata, q;
	logic [1:0]  src, irq, tgl, ph;
	int          bad_count, checks_done, c;
	// register map rows: write, address, data, expected read, expected error
	localparam dcdt_row_t rows [14] = '{
		'{0, 32'hFFF81000, 0, 32'h00000005, 0}, '{0, 32'hFFF81004, 0, 32'h00000005, 0},
		'{0, 32'hFFF81008, 0, 0, 0}, '{0, 32'hFFF8100C, 0, 0, 0}, '{0, 32'hFFF81010, 0, 0, 0},
		'{0, 32'hFFF81014, 0, 0, 0}, '{0, 32'hFFF81018, 0, 0, 0}, '{0, 32'hFFF8101C, 0, 0, 1},
		'{1, 32'hFFF81008, 32'h00ABCDEF, 0, 0}, '{0, 32'hFFF81010, 0, 32'h00ABCDEF, 0},
		'{1, 32'hFFF81010, 32'h00000001, 0, 0}, '{0, 32'hFFF81010, 0, 32'h00ABCDEF, 0},
		'{1, 32'hFFF81004, 32'h8C000012, 0, 0}, '{0, 32'hFFF81004, 0, 32'h88000012, 0}};
	dcdt_apb_host host (.mclk(mclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
	dcdt_timer DUT (.mclk(mclk), .rst_b(rst_b), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.channel_source_clock(src), .debug_acknowledge_in(dbg), .timer_irq(irq), .toggle_out(tgl));
	// 250 MHz clock
	always #2 mclk = ~mclk;
	// source clocks: period of four mclk cycles
	always @(posedge mclk)
	begin
		ph <= ph + 2'h1;
		src <= {2{ph[1]}};
	end
	task automatic stop_test();
		$display("counts: %0d checks, %0d mismatches", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		host.xfer(1'b1, a, d, q, e);
	endtask
	task automatic rd(input logic [31:0] a, input logic [31:0] x, input string n);
		host.xfer(1'b0, a, 32'h00000000, q, e);
		`CHK(n, x, q)
	endtask
	// bounded wait: k 0 is channel 0 irq, k 1 is channel 1 square wave
	task automatic wt(input int k, input logic v);
		c = 0;
		while ((k == 0 ? irq[0] : tgl[1]) !== v)
		begin
			@(posedge mclk);
			#1;
			c++;
			if (c > 400)
			begin
				bad_count++;
				$display("MISMATCH wait exp %h got %h", v, ~v);
				stop_test();
			end
		end
	endtask
	initial
	begin
		// clock enable stays high; the block is frozen otherwise
		mclk = 1'b0;
		rst_b = 1'b0;
		ce = 1'b1;
		dbg = 1'b0;
		ph = 2'h0;
		src = 2'h0;
		repeat (3) @(posedge mclk);
		#1;
		rst_b = 1'b1;
		foreach (rows[i])
		begin
			host.xfer(rows[i].w, rows[i].a, rows[i].d, q, e);
			`CHK("pslverr", rows[i].er, e)
			if (!rows[i].w)
				`CHK("prdata", rows[i].x, q)
		end
		$display("test register map done");
		// periodic with interrupt, prescale 1; initial count never zero
		wr(32'hFFF81008, 32'h00000003);
		wr(32'hFFF81000, 32'h68000001);
		wt(0, 1'b1);
		rd(32'hFFF81018, 32'h00000001, "status");
		rd(32'hFFF81000, 32'h6A000001, "ctrl0");
		// software clears the flag by writing one
		wr(32'hFFF81018, 32'h00000001);
		`CHK("irq0", 1'b0, irq[0])
		wt(0, 1'b1);
		// period is 2 x 3 ticks of 4 cycles, less the 9 cycles of bus traffic since the last event
		`CHK("period", 15, c)
		wr(32'hFFF81000, 32'h04000000);
		rd(32'hFFF81010, 32'h00000000, "cur0");
		rd(32'hFFF81000, 32'h00000000, "ctrl0");
		wr(32'hFFF81018, 32'h00000001);
		$display("test periodic done");
		// one-shot stops itself after one interrupt
		wr(32'hFFF81008, 32'h00000002);
		wr(32'hFFF81000, 32'h60000000);
		wt(0, 1'b1);
		rd(32'hFFF81000, 32'h20000000, "ctrl0");
		wr(32'hFFF81018, 32'h00000001);
		repeat (100) @(posedge mclk);
		`CHK("irq0", 1'b0, irq[0])
		$display("test one-shot done");
		// toggle mode, irq off: half period of 2 ticks of 4 cycles
		wr(32'hFFF8100C, 32'h00000002);
		wr(32'hFFF81004, 32'h50000000);
		wt(1, ~tgl[1]);
		wt(1, ~tgl[1]);
		`CHK("half period", 8, c)
		`CHK("irq1", 1'b0, irq[1])
		$display("test toggle done");
		// debug hold freezes the count unless overridden
		dbg = 1'b1;
		// a long count so that about ten ticks cannot wrap back to the start value
		wr(32'hFFF81008, 32'h00000020);
		wr(32'hFFF81000, 32'h48000000);
		repeat (40) @(posedge mclk);
		rd(32'hFFF81010, 32'h00000020, "held cur0");
		wr(32'hFFF81000, 32'hC8000000);
		repeat (40) @(posedge mclk);
		host.xfer(1'b0, 32'hFFF81010, 32'h00000000, q, e);
		`CHK("running cur0", 1'b1, q !== 32'h00000020)
		$display("test debug hold done");
		// reset in mid-run
		rst_b = 1'b0;
		repeat (3) @(posedge mclk);
		#1;
		rst_b = 1'b1;
		`CHK("tgl", 2'h0, tgl)
		rd(32'hFFF81004, 32'h00000005, "ctrl1");
		$display("test reset done");
		stop_test();
	end
endmodule
`default_nettype wire
